// *** shared/txc_pkg.sv ***
// package: register indices, field positions, modes and fsm states
// assumes: avalon slave uses word addressing, one register per word
package txc_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_ENABLE = 16'hFEEE;
  localparam logic [15:0] IDX_SWVEC  = 16'hFEF3;
  localparam logic [15:0] IDX_MSTPH  = 16'hFF86;
  localparam logic [15:0] IDX_MSTPL  = 16'hFF87;
  localparam logic [7:0]  RST_ENABLE = 8'h00;
  localparam logic [7:0]  RST_SWVEC  = 8'h00;
  localparam logic [7:0]  RST_MSTPH  = 8'h3F;
  localparam logic [7:0]  RST_MSTPL  = 8'hFF;
  localparam int          MSTP_BIT   = 6;
  localparam int          SWV_EN_BIT = 7;
  // transfer_mode_a fields
  localparam int SM_HI     = 7;
  localparam int SM_LO     = 6;
  localparam int DM_HI     = 5;
  localparam int DM_LO     = 4;
  localparam int MD_HI     = 3;
  localparam int MD_LO     = 2;
  localparam int AREA_BIT  = 1;
  localparam int WIDTH_BIT = 0;
  // transfer_mode_b fields
  localparam int CHAIN_BIT = 7;
  localparam int ISEL_BIT  = 6;
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] MD_REPEAT = 2'h1;
  localparam logic [1:0] MD_BLOCK  = 2'h2;
  // descriptor ram window, 32-bit words
  localparam logic [15:0] RAM_BASE   = 16'hEC00;
  localparam logic [15:0] RAM_LAST   = 16'hEFFF;
  localparam int          RAM_AW     = 8;
  localparam logic [7:0]  DESC_WORDS = 8'h03;
  localparam int          SLOT_SHIFT = 4;
  localparam int          ADDR_W     = 24;
  localparam int          N_SRC_DEF  = 8;
  typedef enum logic [3:0] {
    S_IDLE, S_GRANT, S_F0, S_F1, S_F2, S_F3,
    S_RD, S_WR, S_W0, S_W1, S_W2, S_DONE
  } txc_state_type;
endpackage

// *** shared/txc_desc_if.sv ***
// interface: live descriptor and its post-transfer update
// assumes: the controller drives the current values, the updater the next
`timescale 1ns/1ps
interface txc_desc_if;
  logic [7:0]  transfer_mode_a;
  logic [23:0] source_pointer;
  logic [23:0] destination_pointer;
  logic [15:0] count_a;
  logic [15:0] block_count;
  logic [23:0] sar_n;
  logic [23:0] dar_n;
  logic [15:0] cra_n;
  logic [15:0] crb_n;
  logic        blk_end;
  logic        cnt_end;
  modport ctl  (output transfer_mode_a, source_pointer, destination_pointer, count_a, block_count,
                input sar_n, dar_n, cra_n, crb_n, blk_end, cnt_end);
  modport calc (input transfer_mode_a, source_pointer, destination_pointer, count_a, block_count,
                output sar_n, dar_n, cra_n, crb_n, blk_end, cnt_end);
endinterface

// *** hw/txc_upd.sv ***
// updater: next addresses and counters after one item moves
// assumes: inputs are the descriptor in effect for that item
`timescale 1ns/1ps
module txc_upd (
  txc_desc_if.calc d
);
  import txc_pkg::*;

  function automatic logic [23:0] step(input logic [23:0] a,
                                       input logic [1:0] m,
                                       input logic sz);
    logic [23:0] s;
    s = sz ? 24'h000002 : 24'h000001;
    if (!m[1]) return a;
    return m[0] ? a - s : a + s;
  endfunction

  // undo n steps so the area starts over; zero stands for 256
  function automatic logic [23:0] restore(input logic [23:0] a,
                                          input logic [1:0] m,
                                          input logic sz,
                                          input logic [7:0] n);
    logic [23:0] amt;
    amt = {15'h0000, (n == 8'h00), n} << sz;
    if (!m[1]) return a;
    return m[0] ? a + amt : a - amt;
  endfunction

  logic [1:0]  md;
  logic [1:0]  sm;
  logic [1:0]  dm;
  logic        sz;
  logic        is_blk;
  logic        is_norm;
  logic [7:0]  low_n;
  logic [7:0]  rld;
  logic        wrap;
  logic [23:0] s1;
  logic [23:0] d1;

  assign md      = d.transfer_mode_a[MD_HI:MD_LO];
  assign sm      = d.transfer_mode_a[SM_HI:SM_LO];
  assign dm      = d.transfer_mode_a[DM_HI:DM_LO];
  assign sz      = d.transfer_mode_a[WIDTH_BIT];
  assign is_blk  = md == MD_BLOCK; // R9
  assign is_norm = md != MD_REPEAT && !is_blk; // R9
  assign low_n   = d.count_a[7:0] - 8'h01; // R21
  assign rld     = d.count_a[15:8];
  assign wrap    = !is_norm && low_n == 8'h00; // R21
  assign s1      = step(d.source_pointer, sm, sz); // R7
  assign d1      = step(d.destination_pointer, dm, sz); // R8
  assign d.sar_n = (wrap && d.transfer_mode_a[AREA_BIT]) ? restore(s1, sm, sz, rld) : s1; // R10
  assign d.dar_n = (wrap && !d.transfer_mode_a[AREA_BIT]) ? restore(d1, dm, sz, rld) : d1; // R10
  assign d.cra_n = is_norm ? d.count_a - 16'h0001 : {rld, wrap ? rld : low_n}; // R20 R21
  assign d.crb_n = (is_blk && wrap) ? d.block_count - 16'h0001 : d.block_count; // R22
  assign d.blk_end = wrap;
  assign d.cnt_end = is_norm ? d.cra_n == 16'h0000 : // R20
                     (is_blk && wrap && d.crb_n == 16'h0000); // R22
endmodule

// *** hw/txc_pick.sv ***
// picker: chooses the activation and its descriptor slot
// assumes: requests are levels that stay high until serviced
`timescale 1ns/1ps
module txc_pick #(
  parameter int N_SRC = txc_pkg::N_SRC_DEF
) (
  input  wire logic [N_SRC-1:0]  req,
  input  wire logic [N_SRC-1:0]  en,
  input  wire logic              sw_en,
  input  wire logic [2:0]        vec,
  output logic                   hit,
  output logic                   is_sw,
  output logic [2:0]             src,
  output logic [7:0]             slot
);
  import txc_pkg::*;

  logic [N_SRC-1:0] act;

  assign act   = req & en;
  assign hit   = |act | sw_en;
  assign is_sw = ~|act;

  // lowest source index wins; software comes last
  always_comb begin
    src = 3'h0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (act[i]) begin
        src = 3'(i);
      end
    end
  end

  assign slot = is_sw ? 8'({4'h0, 1'b1, vec} << SLOT_SHIFT) : 8'({5'h00, src} << SLOT_SHIFT);
endmodule

// *** hw/txc_top.sv ***
// transfer controller: avalon register slave, descriptor fetch,
// item moves, write-back and end-of-activation handling
// assumes: descriptor ram returns data the cycle after RAM_RE,
// the arbiter answers BUS_REQ with BUS_GRANT, DBUS_ACK ends a strobe
// Functional notes
// R1: start on enabled source or software request
// R2: 24-bit addresses, byte or word items
// R3: descriptor moves over 32-bit ram, one state
// R4: descriptors live only in ram window
// R5: descriptor fields have no register path
// R6: software keeps ram enabled while used
// R7: source pointer fixed, incremented or decremented
// R8: destination pointer fixed, incremented or decremented
// R9: mode field selects normal, repeat, block
// R10: area select picks repeat/block side
// R11: width bit selects byte or word
// R12: chain enable fetches next descriptor, continues
// R13: chained transfer skips end checks, clears
// R14: no chain ends activation, back idle
// R15: interrupt select zero clears source flag
// R16: interrupt select one leaves flag set
// R17: software writes zero to unused bits
// R18: software keeps word source addresses even
// R19: module stop halts; off after reset
// R20: normal mode counts 16 bits down
// R21: repeat/block low count reloads from high
// R22: block mode counts blocks down to zero
// R23: enable bit cleared on interrupt or end
// R24: descriptor written back before bus release
// R25: bus held for whole activation
`timescale 1ns/1ps
module txc_top #(
  parameter int N_SRC = txc_pkg::N_SRC_DEF
) (
  input  wire logic                         CLK,
  input  wire logic                         RSTN,
  input  wire logic [15:0]                  AVS_ADDRESS,
  input  wire logic                         AVS_READ,
  input  wire logic                         AVS_WRITE,
  input  wire logic [31:0]                  AVS_WRITEDATA,
  output logic      [31:0]                  AVS_READDATA,
  output logic                              AVS_WAITREQUEST,
  input  wire logic [N_SRC-1:0]             SRC_REQ,
  output logic      [N_SRC-1:0]             FLAG_CLR,
  output logic                              SW_IRQ,
  output logic                              BUS_REQ,
  input  wire logic                         BUS_GRANT,
  output logic      [txc_pkg::RAM_AW-1:0]   RAM_ADDR,
  output logic                              RAM_RE,
  output logic                              RAM_WE,
  output logic      [31:0]                  RAM_WDATA,
  input  wire logic [31:0]                  RAM_RDATA,
  output logic      [txc_pkg::ADDR_W-1:0]   DBUS_ADDR,
  output logic                              DBUS_RD,
  output logic                              DBUS_WR,
  output logic                              DBUS_WORD,
  output logic      [15:0]                  DBUS_WDATA,
  input  wire logic [15:0]                  DBUS_RDATA,
  input  wire logic                         DBUS_ACK
);
  import txc_pkg::*;

  if (N_SRC < 1 || N_SRC > 8) begin : g_chk
    $error("N_SRC must lie between 1 and 8");
  end

  localparam logic [7:0] SRC_MASK = 8'((1 << N_SRC) - 1);

  txc_state_type st_q, st_d;
  logic [7:0]  en_q, en_d, swv_q, swv_d, mh_q, mh_d, ml_q, ml_d, clr_en;
  logic [7:0]  idx_q, idx_d, mra_q, mra_d, mrb_q, mrb_d, raddr_q, raddr_d;
  logic        swrd_q, swrd_d, wait_q, sw_q, sw_d, cend_q, cend_d, breq_q, breq_d;
  logic        re_q, re_d, we_q, we_d, drd_q, drd_d, dwr_q, dwr_d, dword_q, dword_d;
  logic [31:0] rdat_q, rwd_q, rwd_d;
  logic [2:0]  src_q, src_d;
  logic [23:0] sar_q, sar_d, dar_q, dar_d, daddr_q, daddr_d;
  logic [15:0] cra_q, cra_d, crb_q, crb_d, dat_q, dat_d, dwd_q, dwd_d;
  logic [N_SRC-1:0] fclr_q, fclr_d;
  logic        swirq_q, swirq_d, clr_sw;
  logic        req, acc_rd, acc_wr, hit_en, hit_sv, hit_mh, hit_ml, stop, keep;
  logic [7:0]  rd_mux, onehot;
  assign req    = AVS_READ | AVS_WRITE;
  assign acc_rd = AVS_READ & ~wait_q;
  assign acc_wr = AVS_WRITE & ~wait_q;
  // descriptor fields are absent from the map on purpose
  assign hit_en = AVS_ADDRESS == IDX_ENABLE; // R5
  assign hit_sv = AVS_ADDRESS == IDX_SWVEC;
  assign hit_mh = AVS_ADDRESS == IDX_MSTPH;
  assign hit_ml = AVS_ADDRESS == IDX_MSTPL;
  assign rd_mux = hit_en ? en_q :
                  hit_sv ? swv_q :
                  hit_mh ? mh_q :
                  hit_ml ? ml_q : 8'h00;
  assign stop   = mh_q[MSTP_BIT]; // R19
  assign onehot = 8'h01 << src_q;
  assign keep   = mrb_q[ISEL_BIT] | cend_q; // R16
  // fixed one wait state: answer in the cycle after the request
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wait_q <= 1'b1;
      rdat_q <= 32'h00000000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdat_q <= {24'h000000, rd_mux};
      end
    end
  end
  // software write wins over a hardware clear in the same cycle
  always_comb begin
    en_d   = en_q & ~clr_en; // R23
    swv_d  = swv_q;
    mh_d   = mh_q;
    ml_d   = ml_q;
    swrd_d = swrd_q;
    swv_d[SWV_EN_BIT] = swv_q[SWV_EN_BIT] & ~clr_sw;
    if (acc_rd & hit_sv & swv_q[SWV_EN_BIT]) begin
      swrd_d = 1'b1;
    end
    if (acc_wr & hit_en) begin
      en_d = AVS_WRITEDATA[7:0] & SRC_MASK;
    end
    if (acc_wr & hit_sv) begin
      swrd_d = 1'b0;
      swv_d[SWV_EN_BIT-1:0] = AVS_WRITEDATA[SWV_EN_BIT-1:0];
      // a zero only lands after a one was read back
      if (AVS_WRITEDATA[SWV_EN_BIT] | swrd_q) begin
        swv_d[SWV_EN_BIT] = AVS_WRITEDATA[SWV_EN_BIT];
      end
    end
    if (acc_wr & hit_mh) begin
      mh_d = AVS_WRITEDATA[7:0];
    end
    if (acc_wr & hit_ml) begin
      ml_d = AVS_WRITEDATA[7:0];
    end
  end
  logic       p_hit, p_sw;
  logic [2:0] p_src;
  logic [7:0] p_slot;
  txc_pick #(
    .N_SRC (N_SRC)
  ) u_pick (
    .req   (SRC_REQ),
    .en    (en_q[N_SRC-1:0]),
    .sw_en (swv_q[SWV_EN_BIT]),
    .vec   (swv_q[2:0]),
    .hit   (p_hit),
    .is_sw (p_sw),
    .src   (p_src),
    .slot  (p_slot)
  );
  txc_desc_if dif ();
  assign dif.transfer_mode_a = mra_q;
  assign dif.source_pointer = sar_q;
  assign dif.destination_pointer = dar_q;
  assign dif.count_a = cra_q;
  assign dif.block_count = crb_q;
  txc_upd u_upd (
    .d (dif)
  );
  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    src_d   = src_q;
    sw_d    = sw_q;
    mra_d   = mra_q;
    mrb_d   = mrb_q;
    sar_d   = sar_q;
    dar_d   = dar_q;
    cra_d   = cra_q;
    crb_d   = crb_q;
    dat_d   = dat_q;
    cend_d  = cend_q;
    breq_d  = breq_q;
    raddr_d = raddr_q;
    re_d    = re_q;
    we_d    = we_q;
    rwd_d   = rwd_q;
    daddr_d = daddr_q;
    drd_d   = drd_q;
    dwr_d   = dwr_q;
    dword_d = dword_q;
    dwd_d   = dwd_q;
    fclr_d  = '0;
    swirq_d = 1'b0;
    clr_en  = 8'h00;
    clr_sw  = 1'b0;
    case (st_q)
      S_IDLE: begin
        // stop only blocks new activations; one in flight completes
        if (p_hit & ~stop) begin // R1 R19
          st_d   = S_GRANT;
          breq_d = 1'b1; // R25
          idx_d  = p_slot;
          src_d  = p_src;
          sw_d   = p_sw;
        end
      end
      S_GRANT: begin
        if (BUS_GRANT) begin
          st_d    = S_F0;
          raddr_d = idx_q; // R4
          re_d    = 1'b1;
        end
      end
      S_F0: begin
        st_d    = S_F1;
        raddr_d = idx_q + 8'h01;
      end
      S_F1: begin
        st_d    = S_F2;
        raddr_d = idx_q + 8'h02;
        mra_d   = RAM_RDATA[31:24]; // R3
        sar_d   = RAM_RDATA[23:0];
      end
      S_F2: begin
        st_d  = S_F3;
        re_d  = 1'b0;
        mrb_d = RAM_RDATA[31:24]; // R3
        dar_d = RAM_RDATA[23:0];
      end
      S_F3: begin
        st_d  = S_RD;
        cra_d = RAM_RDATA[31:16]; // R3
        crb_d = RAM_RDATA[15:0];
      end
      S_RD: begin
        daddr_d = sar_q; // R2
        dword_d = mra_q[WIDTH_BIT]; // R11
        drd_d   = 1'b1;
        if (drd_q & DBUS_ACK) begin
          drd_d = 1'b0;
          dat_d = DBUS_RDATA;
          st_d  = S_WR;
        end
      end
      S_WR: begin
        daddr_d = dar_q; // R2
        dwd_d   = dat_q;
        dwr_d   = 1'b1;
        if (dwr_q & DBUS_ACK) begin
          dwr_d  = 1'b0;
          sar_d  = dif.sar_n;
          dar_d  = dif.dar_n;
          cra_d  = dif.cra_n;
          crb_d  = dif.crb_n;
          cend_d = dif.cnt_end;
          if (mra_q[MD_HI:MD_LO] == MD_BLOCK && !dif.blk_end) begin
            st_d = S_RD;
          end else begin
            st_d    = S_W0;
            raddr_d = idx_q; // R24
            we_d    = 1'b1;
            rwd_d   = {mra_q, dif.sar_n};
          end
        end
      end
      S_W0: begin
        st_d    = S_W1;
        raddr_d = idx_q + 8'h01; // R24
        rwd_d   = {mrb_q, dar_q};
      end
      S_W1: begin
        st_d    = S_W2;
        raddr_d = idx_q + 8'h02; // R24
        rwd_d   = {cra_q, crb_q};
      end
      S_W2: begin
        we_d = 1'b0;
        if (mrb_q[CHAIN_BIT]) begin
          st_d    = S_F0; // R12 R13
          idx_d   = idx_q + DESC_WORDS;
          raddr_d = idx_q + DESC_WORDS;
          re_d    = 1'b1;
        end else begin
          st_d   = S_DONE; // R14
          breq_d = 1'b0; // R25
          if (sw_q) begin
            swirq_d = keep;
            clr_sw  = ~keep;
          end else if (keep) begin
            clr_en = onehot; // R16 R23
          end else begin
            fclr_d = onehot[N_SRC-1:0]; // R15
          end
        end
      end
      S_DONE: begin
        // gives the source one cycle to drop its flag
        st_d = S_IDLE;
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end
  // descriptor copies need no reset: each is loaded before use
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_q    <= S_IDLE;
      en_q    <= RST_ENABLE;
      swv_q   <= RST_SWVEC;
      mh_q    <= RST_MSTPH; // R19
      ml_q    <= RST_MSTPL;
      swrd_q  <= 1'b0;
      breq_q  <= 1'b0;
      raddr_q <= 8'h00;
      re_q    <= 1'b0;
      we_q    <= 1'b0;
      rwd_q   <= 32'h00000000;
      daddr_q <= 24'h000000;
      drd_q   <= 1'b0;
      dwr_q   <= 1'b0;
      dword_q <= 1'b0;
      dwd_q   <= 16'h0000;
      fclr_q  <= '0;
      swirq_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      en_q    <= en_d;
      swv_q   <= swv_d;
      mh_q    <= mh_d;
      ml_q    <= ml_d;
      swrd_q  <= swrd_d;
      idx_q   <= idx_d;
      src_q   <= src_d;
      sw_q    <= sw_d;
      mra_q   <= mra_d;
      mrb_q   <= mrb_d;
      sar_q   <= sar_d;
      dar_q   <= dar_d;
      cra_q   <= cra_d;
      crb_q   <= crb_d;
      dat_q   <= dat_d;
      cend_q  <= cend_d;
      breq_q  <= breq_d;
      raddr_q <= raddr_d;
      re_q    <= re_d;
      we_q    <= we_d;
      rwd_q   <= rwd_d;
      daddr_q <= daddr_d;
      drd_q   <= drd_d;
      dwr_q   <= dwr_d;
      dword_q <= dword_d;
      dwd_q   <= dwd_d;
      fclr_q  <= fclr_d;
      swirq_q <= swirq_d;
    end
  end
  assign AVS_READDATA    = rdat_q;
  assign AVS_WAITREQUEST = wait_q;
  assign FLAG_CLR        = fclr_q;
  assign SW_IRQ          = swirq_q;
  assign BUS_REQ         = breq_q;
  assign RAM_ADDR        = raddr_q;
  assign RAM_RE          = re_q;
  assign RAM_WE          = we_q;
  assign RAM_WDATA       = rwd_q;
  assign DBUS_ADDR       = daddr_q;
  assign DBUS_RD         = drd_q;
  assign DBUS_WR         = dwr_q;
  assign DBUS_WORD       = dword_q;
  assign DBUS_WDATA      = dwd_q;
endmodule

// *** tb/txc_far_model.sv ***
// far side: descriptor ram, bus arbiter and data bus slave
// assumes: bench seeds ram[] and reads the logs by hierarchy
`timescale 1ns/1ps
module txc_far_model (
  input  wire logic        clk,
  input  wire logic [1:0]  slow,
  input  wire logic        bus_req,
  output logic             bus_grant,
  input  wire logic [7:0]  ram_addr,
  input  wire logic        ram_re,
  input  wire logic        ram_we,
  input  wire logic [31:0] ram_wdata,
  output logic      [31:0] ram_rdata,
  input  wire logic [23:0] dbus_addr,
  input  wire logic        dbus_rd,
  input  wire logic        dbus_wr,
  input  wire logic        dbus_word,
  input  wire logic [15:0] dbus_wdata,
  output logic      [15:0] dbus_rdata,
  output logic             dbus_ack
);
  logic [31:0] ram [256];
  logic [1:0]  wait_q;
  logic [23:0] rd_a [$];
  logic [23:0] wr_a [$];
  logic [15:0] wr_d [$];
  logic        wr_w [$];
  initial begin
    bus_grant = 1'b0;
    ram_rdata = 32'h0;
    dbus_rdata = 16'h0;
    dbus_ack = 1'b0;
    wait_q = 2'h0;
  end
  // idle read lines toggle so stale data never looks valid
  always @(posedge clk) begin
    bus_grant <= bus_req;
    ram_rdata <= ram_re ? ram[ram_addr] : ~ram_rdata;
    if (ram_we)
      ram[ram_addr] <= ram_wdata;
    dbus_ack <= 1'b0;
    dbus_rdata <= ~dbus_rdata;
    // never answers in the first strobe cycle: ack rises slow+1 cycles after the strobe, address and data may land late
    if ((dbus_rd || dbus_wr) && !dbus_ack) begin
      if (wait_q == slow) begin
        wait_q <= 2'h0;
        dbus_ack <= 1'b1;
        if (dbus_rd) begin
          rd_a.push_back(dbus_addr);
          dbus_rdata <= dbus_addr[15:0] ^ 16'hC3A5;
        end else begin
          wr_a.push_back(dbus_addr);
          wr_d.push_back(dbus_wdata);
          wr_w.push_back(dbus_word);
        end
      end else
        wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// *** tb/txc_monitor.sv ***
// checker: port timing of the transfer controller
// assumes: bound into txc_top, one clock, sync active-low reset
`timescale 1ns/1ps
module txc_monitor #(
  parameter int N_SRC = 8
) (
  input wire logic                     CLK,
  input wire logic                     RSTN,
  input wire logic                     AVS_READ,
  input wire logic                     AVS_WRITE,
  input wire logic [31:0]              AVS_READDATA,
  input wire logic                     AVS_WAITREQUEST,
  input wire logic [N_SRC-1:0]         FLAG_CLR,
  input wire logic                     SW_IRQ,
  input wire logic                     BUS_REQ,
  input wire logic                     BUS_GRANT,
  input wire logic [txc_pkg::RAM_AW-1:0] RAM_ADDR,
  input wire logic                     RAM_RE,
  input wire logic                     RAM_WE,
  input wire logic [txc_pkg::ADDR_W-1:0] DBUS_ADDR,
  input wire logic                     DBUS_RD,
  input wire logic                     DBUS_WR,
  input wire logic                     DBUS_ACK
);
  import txc_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_fetch;
    (RAM_RE && RAM_ADDR == $past(RAM_ADDR) + 8'h01) [*2] ##1 !RAM_RE;
  endsequence
  sequence s_wb;
    (RAM_WE && RAM_ADDR == $past(RAM_ADDR) + 8'h01) [*2] ##1 !RAM_WE;
  endsequence
  a_fetch_words:
    assert property ($rose(RAM_RE) |=> s_fetch) else $error("fetch not three words");
  a_wb_words:
    assert property ($rose(RAM_WE) |=> s_wb) else $error("write-back not three words");
  a_wait_once:
    assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("wait state not single");
  a_idle_wait:
    assert property (!(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST) else $error("stray answer");
  a_read_upper:
    assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0) else $error("upper bits");
  a_bus_held:
    assert property (RAM_RE || RAM_WE || DBUS_RD || DBUS_WR |-> BUS_REQ && BUS_GRANT)
      else $error("access without bus");
  a_rd_hold:
    assert property (DBUS_RD && $past(DBUS_RD) && !DBUS_ACK |=> DBUS_RD && $stable(DBUS_ADDR))
      else $error("read strobe dropped");
  a_wr_hold:
    assert property (DBUS_WR && !DBUS_ACK |=> DBUS_WR) else $error("write strobe dropped");
  a_strobe_gap:
    assert property ($fell(DBUS_RD) |-> !DBUS_WR && !DBUS_RD) else $error("no idle cycle");
  a_flag_pulse:
    assert property (FLAG_CLR != '0 |-> $onehot(FLAG_CLR) && !BUS_REQ ##1 FLAG_CLR == '0)
      else $error("flag clear not single pulse");
  a_irq_pulse:
    assert property (SW_IRQ |-> !BUS_REQ ##1 !SW_IRQ) else $error("irq not single pulse");
endmodule
bind txc_top txc_monitor #(.N_SRC(N_SRC)) u_mon (.*);

// *** tb/tb_top.sv ***
// bench: random and corner activations through txc_top
// assumes: txc_far_model answers ram, arbiter and data bus
`timescale 1ns/1ps
module tb_top;
  import txc_pkg::*;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [15:0] AVS_ADDRESS = 16'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [7:0] SRC_REQ = 8'h0;
  logic [31:0] AVS_READDATA, RAM_WDATA, RAM_RDATA;
  logic AVS_WAITREQUEST, SW_IRQ, BUS_REQ, BUS_GRANT, RAM_RE, RAM_WE;
  logic DBUS_RD, DBUS_WR, DBUS_WORD, DBUS_ACK;
  logic [7:0] FLAG_CLR;
  logic [RAM_AW-1:0] RAM_ADDR;
  logic [23:0] DBUS_ADDR;
  logic [15:0] DBUS_WDATA, DBUS_RDATA;
  logic [1:0] slow = 2'h1;
  logic [31:0] seed = 32'h73AE;
  int fail_count = 0;
  int n_compared = 0;
  int flags = 0;
  int irqs = 0;
  always #20 CLK = ~CLK;
  txc_top #(.N_SRC(8)) dut (.*);
  txc_far_model far (.clk(CLK), .slow(slow), .bus_req(BUS_REQ), .bus_grant(BUS_GRANT),
    .ram_addr(RAM_ADDR), .ram_re(RAM_RE), .ram_we(RAM_WE), .ram_wdata(RAM_WDATA),
    .ram_rdata(RAM_RDATA), .dbus_addr(DBUS_ADDR), .dbus_rd(DBUS_RD), .dbus_wr(DBUS_WR),
    .dbus_word(DBUS_WORD), .dbus_wdata(DBUS_WDATA), .dbus_rdata(DBUS_RDATA),
    .dbus_ack(DBUS_ACK));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [23:0] nxt(logic [23:0] a, logic [1:0] m, logic sz);
    return m[1] ? (m[0] ? a - (sz ? 24'h2 : 24'h1) : a + (sz ? 24'h2 : 24'h1)) : a;
  endfunction
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int k;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
    if (k >= 50)
      fail_count++;
    q = AVS_READDATA[7:0];
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    av(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    av(1'b0, a, 8'h0, q);
    chk(q, e);
  endtask
  task automatic put(input logic [7:0] i, input logic [7:0] ma, input logic [7:0] mb,
                     input logic [23:0] s, input logic [23:0] d, input logic [31:0] c);
    far.ram[i] = {ma, s};
    far.ram[i + 8'h1] = {mb, d};
    far.ram[i + 8'h2] = c;
  endtask
  task automatic run();
    int k;
    k = 0;
    while (BUS_REQ !== 1'b1 && k < 40) begin
      @(negedge CLK);
      k++;
    end
    while (BUS_REQ !== 1'b0 && k < 400) begin
      @(negedge CLK);
      k++;
    end
    repeat (3) @(negedge CLK);
    chk(k < 400, 1'b1);
  endtask
  task automatic fire(input logic [2:0] n, input logic [7:0] en);
    far.rd_a.delete();
    far.wr_a.delete();
    far.wr_d.delete();
    far.wr_w.delete();
    flags = 0;
    wreg(IDX_ENABLE, en);
    SRC_REQ[n] <= 1'b1;
    run();
  endtask
  // source drops its request at the edge that ends the clear pulse
  always @(posedge CLK) begin
    if (SW_IRQ === 1'b1)
      irqs++;
    if (FLAG_CLR !== 8'h0) begin
      flags++;
      SRC_REQ <= SRC_REQ & ~FLAG_CLR;
    end
  end
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
  initial begin
    logic [31:0] rv;
    logic [7:0] ma, mb, ix;
    logic [23:0] s;
    logic [15:0] c;
    logic keep;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rchk(IDX_ENABLE, RST_ENABLE);
    rchk(IDX_SWVEC, RST_SWVEC);
    rchk(IDX_MSTPH, RST_MSTPH);
    rchk(IDX_MSTPL, RST_MSTPL);
    rchk(16'h1234, 8'h00);
    wreg(IDX_MSTPL, 8'hA5);
    rchk(IDX_MSTPL, 8'hA5);
    for (int i = 0; i < 10; i++) begin
      rv = rnd();
      ma = {rv[7:4], 3'h0, rv[8]};
      mb = {1'b0, rv[9], 6'h0};
      c = {14'h0, rv[11:10]} + 16'h1;
      slow <= rv[13:12] | 2'h1;
      ix = {1'b0, rv[16:14], 4'h0};
      s = {rv[31:9], rv[17] & ~ma[0]};
      rv = rnd();
      put(ix, ma, mb, s, {rv[23:1], 1'b0}, {c, 16'h0});
      keep = mb[6] | (c == 16'h1);
      fire(ix[6:4], 8'h01 << ix[6:4]);
      chk(far.rd_a[0], s);
      chk(far.wr_a[0], {rv[23:1], 1'b0});
      chk(far.wr_w[0], ma[0]);
      chk(far.wr_d[0] & (ma[0] ? 16'hFFFF : 16'h00FF),
          (s[15:0] ^ 16'hC3A5) & (ma[0] ? 16'hFFFF : 16'h00FF));
      chk(far.ram[ix], {ma, nxt(s, ma[7:6], ma[0])});
      chk(far.ram[ix + 8'h1], {mb, nxt({rv[23:1], 1'b0}, ma[5:4], ma[0])});
      chk(far.ram[ix + 8'h2][31:16], c - 16'h1);
      chk(flags, !keep);
      rchk(IDX_ENABLE, keep ? 8'h00 : 8'h01 << ix[6:4]);
      SRC_REQ <= 8'h0;
    end
    put(8'h20, 8'hA0, 8'h80, 24'h001000, 24'h002000, 32'h00010000);
    put(8'h23, 8'h00, 8'h00, 24'h003000, 24'h004000, 32'h00050000);
    fire(3'h2, 8'h04);
    chk(far.wr_a.size(), 2);
    chk(far.wr_a[1], 24'h004000);
    chk(flags, 1);
    chk(far.ram[8'h25][31:16], 16'h0004);
    rchk(IDX_ENABLE, 8'h04);
    put(8'h30, 8'hA4, 8'h00, 24'h005000, 24'h006000, 32'h02010000);
    fire(3'h3, 8'h08);
    chk(far.ram[8'h32], 32'h02020000);
    chk(far.ram[8'h30][23:0], 24'h005001);
    chk(flags, 1);
    rchk(IDX_ENABLE, 8'h08);
    put(8'h40, 8'h8A, 8'h00, 24'h007000, 24'h008000, 32'h03030001);
    fire(3'h4, 8'h10);
    chk(far.wr_a.size(), 3);
    chk(far.rd_a[2], 24'h007002);
    chk(far.ram[8'h40][23:0], 24'h007000);
    chk(far.ram[8'h42], 32'h03030000);
    chk(flags, 0);
    rchk(IDX_ENABLE, 8'h00);
    SRC_REQ <= 8'h0;
    wreg(IDX_MSTPH, 8'h7F);
    put(8'h50, 8'h00, 8'h00, 24'h009000, 24'h00A000, 32'h00020000);
    flags = 0;
    wreg(IDX_ENABLE, 8'h20);
    SRC_REQ[5] <= 1'b1;
    repeat (20) @(negedge CLK);
    chk(BUS_REQ, 1'b0);
    wreg(IDX_MSTPH, RST_MSTPH);
    run();
    chk(flags, 1);
    put(8'hB0, 8'h00, 8'h00, 24'h00B000, 24'h00C000, 32'h00040000);
    irqs = 0;
    wreg(IDX_SWVEC, 8'h83);
    run();
    rchk(IDX_SWVEC, 8'h03);
    chk(irqs, 0);
    far.ram[8'hB1] = {8'h40, 24'h00C000};
    wreg(IDX_SWVEC, 8'h83);
    run();
    rchk(IDX_SWVEC, 8'h83);
    wreg(IDX_SWVEC, 8'h00);
    repeat (40) @(negedge CLK);
    chk(irqs > 0, 1'b1);
    rchk(IDX_SWVEC, 8'h00);
    summarize();
  end
endmodule
